// ==== common/cep_pkg.sv ====
`default_nettype none
package cep_pkg;
   // ------------------------------------------------------------
   // vectors and offsets
   // ------------------------------------------------------------
   localparam logic [31:0] CEP_RESET_VEC = 32'hBFC00000;
   localparam logic [31:0] CEP_DEBUG_VEC = 32'hBFC00480;
   localparam logic [31:0] CEP_GEN_OFS = 32'h00000180;
   localparam logic [31:0] CEP_BASE_RST = 32'h80000000;

   // ------------------------------------------------------------
   // cause codes
   // ------------------------------------------------------------
   localparam logic [4:0] CEP_CC_INT = 5'h00;
   localparam logic [4:0] CEP_CC_FETCH_TRANSLATION_MISS = 5'h02;
   localparam logic [4:0] CEP_CC_FETCH_ADDRESS_ERROR = 5'h04;
   localparam logic [4:0] CEP_CC_IBE = 5'h06;
   localparam logic [4:0] CEP_CC_XI = 5'h14;
   localparam logic [4:0] CEP_CC_WATCH = 5'h17;
   localparam logic [4:0] CEP_CC_MACHINE_CHECK_FLAG = 5'h18;

   // ------------------------------------------------------------
   // register map (word index = address)
   // ------------------------------------------------------------
   localparam logic [3:0] CEP_A_STATUS = 4'h0;
   localparam logic [3:0] CEP_A_DEBUG = 4'h1;
   localparam logic [3:0] CEP_A_CAUSE = 4'h2;
   localparam logic [3:0] CEP_A_BASE = 4'h3;
   localparam logic [3:0] CEP_A_ISTAT = 4'h4;
   localparam logic [3:0] CEP_A_ICLR = 4'h5;
   localparam logic [3:0] CEP_A_IEN = 4'h6;
   localparam logic [3:0] CEP_A_DCTL = 4'h7;

   // status bit positions
   localparam int CEP_ST_EXL = 0;
   localparam int CEP_ST_ERL = 1;
   localparam int CEP_ST_NMI = 2;
   localparam int CEP_ST_SR = 3;
   localparam int CEP_ST_WP = 4;
   localparam int CEP_ST_MACHINE_CHECK_FLAG = 5;
   localparam int CEP_ST_BEV = 6;
   localparam int CEP_ST_IPL = 8;
   // debug flag positions
   localparam int CEP_DB_DSS = 0;
   localparam int CEP_DB_DEBUG_INTERRUPT_FLAG = 1;
   localparam int CEP_DB_DIB = 2;

   // event indices, highest priority first
   localparam int CEP_NEV = 14;
   localparam int CEP_E_RST = 0;
   localparam int CEP_E_SRST = 1;
   localparam int CEP_E_DSS = 2;
   localparam int CEP_E_DEBUG_INTERRUPT_FLAG = 3;
   localparam int CEP_E_NMI = 4;
   localparam int CEP_E_MCHK = 5;
   localparam int CEP_E_INT = 6;
   localparam int CEP_E_DWP = 7;
   localparam int CEP_E_DIB = 8;
   localparam int CEP_E_WATCH = 9;
   localparam int CEP_E_FETCH_ADDRESS_ERROR = 10;
   localparam int CEP_E_FETCH_TRANSLATION_MISS = 11;
   localparam int CEP_E_XI = 12;
   localparam int CEP_E_IBE = 13;
endpackage : cep_pkg
`default_nettype wire

// ==== rtl/cep_prioritizer.sv ====
// Contract
// [RULE_01] events are ranked with reset first and only the top pending one is taken.
// [RULE_02] master clear or power-on reset vectors to the reset vector and sets boot vector select and error level.
// [RULE_03] soft reset vectors to the reset vector and sets boot vector select, soft reset and error level.
// [RULE_04] debug single step vectors to the debug vector, sets its debug flag and writes no status or cause.
// [RULE_05] debug interrupt comes from the external request or the break request bit and vectors to the debug vector.
// [RULE_06] non-maskable interrupt vectors to the reset vector and sets boot vector select, nmi and error level.
// [RULE_07] a conflicting translation write is a machine check at base plus 0x180 with cause 0x18.
// [RULE_08] an unmasked interrupt is taken with cause 0x00, updates the priority level and uses its own vector.
// [RULE_09] a deferred watch taken on unmask goes to base plus 0x180 with watch pending, exl and cause 0x17.
// [RULE_10] an instruction break match vectors to the debug vector and sets its debug flag.
// [RULE_11] a fetch watch match goes to base plus 0x180 with exl and cause 0x17.
// [RULE_12] a misaligned or protected fetch goes to base plus 0x180 with exl and cause 0x04.
// [RULE_13] a fetch translation miss records 0x02 and goes to base, or base plus 0x180 if exl is set.
// [RULE_14] an execute-inhibited fetch hit goes to base plus 0x180 with exl and cause 0x14.
// [RULE_15] a fetch bus error goes to base plus 0x180 with exl and cause 0x06.
// [RULE_16] the cause code stays readable until the next exception overwrites it.
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none
module cep_prioritizer #(
   parameter int IPL_W = 3
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic master_clear_pin,
   input wire logic soft_reset_req,
   input wire logic debug_single_step,
   input wire logic external_debug_request_input,
   input wire logic nmi_in,
   input wire logic tlb_write_conflict,
   input wire logic int_req,
   input wire logic [IPL_W-1:0] int_level,
   input wire logic [31:0] int_vector,
   input wire logic deferred_watch_unmask,
   input wire logic debug_instr_break,
   input wire logic fetch_watch_match,
   input wire logic fetch_address_error,
   input wire logic fetch_translation_miss,
   input wire logic execute_inhibit_bit,
   input wire logic fetch_bus_error,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic exc_taken,
   output logic [31:0] exc_target,
   output logic irq
);
   import cep_pkg::*;

   initial
   begin
      if (IPL_W < 1 || IPL_W > 8)
      begin
         $error("IPL_W must be 1 to 8");
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [15:0] status_r;
   logic [2:0] debug_r;
   logic [4:0] cause_r;
   logic [31:0] base_r;
   logic break_req_r;
   logic [CEP_NEV-1:0] istat_r;
   logic [CEP_NEV-1:0] ien_r;
   logic [CEP_NEV-1:0] ev;
   logic [CEP_NEV-1:0] grant;
   logic [31:0] gen_vec;

   // first-one pick: lower index wins
   function automatic logic [CEP_NEV-1:0] pick_top(
      input logic [CEP_NEV-1:0] req
   );
      logic [CEP_NEV-1:0] g;
      logic found;
      g = '0;
      found = 1'b0;
      for (int i = 0; i < CEP_NEV; i++)
      begin
         if (req[i] && !found)
         begin
            g[i] = 1'b1;
            found = 1'b1;
         end
      end
      return g;
   endfunction : pick_top

   // ------------------------------------------------------------
   // event collection and priority
   // ------------------------------------------------------------
   always_comb
   begin
      ev = '0;
      ev[CEP_E_RST] = master_clear_pin;
      ev[CEP_E_SRST] = soft_reset_req;
      ev[CEP_E_DSS] = debug_single_step;
      // break request bit acts as a second source for the same event
      ev[CEP_E_DEBUG_INTERRUPT_FLAG] = external_debug_request_input | break_req_r; // see [RULE_05]
      ev[CEP_E_NMI] = nmi_in;
      ev[CEP_E_MCHK] = tlb_write_conflict;
      ev[CEP_E_INT] = int_req;
      ev[CEP_E_DWP] = deferred_watch_unmask;
      ev[CEP_E_DIB] = debug_instr_break;
      ev[CEP_E_WATCH] = fetch_watch_match;
      ev[CEP_E_FETCH_ADDRESS_ERROR] = fetch_address_error;
      ev[CEP_E_FETCH_TRANSLATION_MISS] = fetch_translation_miss;
      ev[CEP_E_XI] = execute_inhibit_bit;
      ev[CEP_E_IBE] = fetch_bus_error;
      grant = pick_top(ev); // see [RULE_01]
      gen_vec = base_r + CEP_GEN_OFS;
   end

   // ------------------------------------------------------------
   // branch target and taken strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         exc_taken <= 1'b0;
         exc_target <= CEP_RESET_VEC;
      end
      else
      begin
         exc_taken <= |ev;
         if (grant[CEP_E_RST] || grant[CEP_E_SRST] || grant[CEP_E_NMI])
            exc_target <= CEP_RESET_VEC; // see [RULE_02] [RULE_03] [RULE_06]
         else if (grant[CEP_E_DSS] || grant[CEP_E_DEBUG_INTERRUPT_FLAG] || grant[CEP_E_DIB])
            exc_target <= CEP_DEBUG_VEC; // see [RULE_04] [RULE_05] [RULE_10]
         else if (grant[CEP_E_INT])
            exc_target <= int_vector; // see [RULE_08]
         else if (grant[CEP_E_FETCH_TRANSLATION_MISS] && !status_r[CEP_ST_EXL])
            exc_target <= base_r; // see [RULE_13]
         else if (|ev)
            exc_target <= gen_vec; // see [RULE_07] [RULE_09] [RULE_11]
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   // an exception that sets status bits wins; a software write in the same cycle is dropped
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         status_r <= 16'h0000;
         status_r[CEP_ST_BEV] <= 1'b1;
         status_r[CEP_ST_ERL] <= 1'b1;
      end
      else if (grant[CEP_E_RST])
      begin
         status_r[CEP_ST_BEV] <= 1'b1; // see [RULE_02]
         status_r[CEP_ST_ERL] <= 1'b1;
      end
      else if (grant[CEP_E_SRST])
      begin
         status_r[CEP_ST_BEV] <= 1'b1; // see [RULE_03]
         status_r[CEP_ST_SR] <= 1'b1;
         status_r[CEP_ST_ERL] <= 1'b1;
      end
      else if (grant[CEP_E_NMI])
      begin
         status_r[CEP_ST_BEV] <= 1'b1; // see [RULE_06]
         status_r[CEP_ST_NMI] <= 1'b1;
         status_r[CEP_ST_ERL] <= 1'b1;
      end
      else if (grant[CEP_E_MCHK])
      begin
         status_r[CEP_ST_MACHINE_CHECK_FLAG] <= 1'b1; // see [RULE_07]
         status_r[CEP_ST_EXL] <= 1'b1;
      end
      else if (grant[CEP_E_INT])
         status_r[CEP_ST_IPL +: IPL_W] <= int_level; // see [RULE_08]
      else if (grant[CEP_E_DWP])
      begin
         status_r[CEP_ST_WP] <= 1'b1; // see [RULE_09]
         status_r[CEP_ST_EXL] <= 1'b1;
      end
      else if (grant[CEP_E_WATCH] || grant[CEP_E_FETCH_ADDRESS_ERROR] ||
               grant[CEP_E_XI] || grant[CEP_E_IBE])
         status_r[CEP_ST_EXL] <= 1'b1; // see [RULE_11] [RULE_12] [RULE_14] [RULE_15]
      else if (reg_wr && reg_addr == CEP_A_STATUS)
         status_r <= reg_wdata[15:0];
   end

   // ------------------------------------------------------------
   // debug flags and break request bit
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         debug_r <= 3'h0;
         break_req_r <= 1'b0;
      end
      else
      begin
         if (grant[CEP_E_DSS])
            debug_r[CEP_DB_DSS] <= 1'b1; // see [RULE_04]
         else if (grant[CEP_E_DEBUG_INTERRUPT_FLAG])
            debug_r[CEP_DB_DEBUG_INTERRUPT_FLAG] <= 1'b1; // see [RULE_05]
         else if (grant[CEP_E_DIB])
            debug_r[CEP_DB_DIB] <= 1'b1; // see [RULE_10]
         else if (reg_wr && reg_addr == CEP_A_DEBUG)
            debug_r <= reg_wdata[2:0];
         // request self-clears once the debug interrupt is taken
         if (grant[CEP_E_DEBUG_INTERRUPT_FLAG])
            break_req_r <= 1'b0;
         else if (reg_wr && reg_addr == CEP_A_DCTL)
            break_req_r <= reg_wdata[0]; // see [RULE_05]
      end
   end

   // ------------------------------------------------------------
   // cause code and exception base
   // ------------------------------------------------------------
   // debug, reset and nmi leave the cause untouched
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         cause_r <= 5'h00;
      else if (grant[CEP_E_MCHK])
         cause_r <= CEP_CC_MACHINE_CHECK_FLAG; // see [RULE_07]
      else if (grant[CEP_E_INT])
         cause_r <= CEP_CC_INT; // see [RULE_08]
      else if (grant[CEP_E_DWP] || grant[CEP_E_WATCH])
         cause_r <= CEP_CC_WATCH; // see [RULE_09] [RULE_11]
      else if (grant[CEP_E_FETCH_ADDRESS_ERROR])
         cause_r <= CEP_CC_FETCH_ADDRESS_ERROR; // see [RULE_12]
      else if (grant[CEP_E_FETCH_TRANSLATION_MISS])
         cause_r <= CEP_CC_FETCH_TRANSLATION_MISS; // see [RULE_13]
      else if (grant[CEP_E_XI])
         cause_r <= CEP_CC_XI; // see [RULE_14]
      else if (grant[CEP_E_IBE])
         cause_r <= CEP_CC_IBE; // see [RULE_15]
   end // held otherwise, see [RULE_16]

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         base_r <= CEP_BASE_RST;
      else if (reg_wr && reg_addr == CEP_A_BASE)
         base_r <= {reg_wdata[31:12], 12'h000}; // base kept 4 KB aligned
   end

   // ------------------------------------------------------------
   // event interrupt: sticky status, clear, enable
   // ------------------------------------------------------------
   // an event in the clear cycle survives: set wins over clear
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         istat_r <= '0;
         ien_r <= '0;
         irq <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == CEP_A_ICLR)
            istat_r <= (istat_r & ~reg_wdata[CEP_NEV-1:0]) | grant;
         else
            istat_r <= istat_r | grant;
         if (reg_wr && reg_addr == CEP_A_IEN)
            ien_r <= reg_wdata[CEP_NEV-1:0];
         irq <= |(istat_r & ien_r);
      end
   end

   // ------------------------------------------------------------
   // read port, data one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
      begin
         case (reg_addr)
            CEP_A_STATUS: reg_rdata <= {16'h0000, status_r};
            CEP_A_DEBUG: reg_rdata <= {29'h0, debug_r};
            CEP_A_CAUSE: reg_rdata <= {27'h0, cause_r}; // see [RULE_16]
            CEP_A_BASE: reg_rdata <= base_r;
            CEP_A_ISTAT: reg_rdata <= {{(32-CEP_NEV){1'b0}}, istat_r};
            CEP_A_IEN: reg_rdata <= {{(32-CEP_NEV){1'b0}}, ien_r};
            CEP_A_DCTL: reg_rdata <= {31'h0, break_req_r};
            default: reg_rdata <= 32'h00000000;
         endcase
      end
      else
         reg_rdata <= 32'h00000000;
   end
endmodule : cep_prioritizer
`default_nettype wire

// ==== verification/cep_prioritizer_sva.sv ====
`default_nettype none
module cep_prioritizer_chk (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic master_clear_pin,
   input wire logic soft_reset_req,
   input wire logic debug_single_step,
   input wire logic external_debug_request_input,
   input wire logic nmi_in,
   input wire logic tlb_write_conflict,
   input wire logic int_req,
   input wire logic [31:0] int_vector,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic exc_taken,
   input wire logic [31:0] exc_target
);
   import cep_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   // ---------------------------------------------------------------
   // priority ladder: each step means no input pin above it is pending; the break request bit is not checked
   // ---------------------------------------------------------------
   sequence s_rst_free;
      !master_clear_pin && !soft_reset_req;
   endsequence
   sequence s_dbg_free;
      s_rst_free ##0 (!debug_single_step && !external_debug_request_input);
   endsequence
   sequence s_nmi_free;
      s_dbg_free ##0 !nmi_in;
   endsequence
   // ---------------------------------------------------------------
   // vectors one cycle after the winning request
   // ---------------------------------------------------------------
   AST_RESET_VEC: assert property (
      master_clear_pin |=> exc_taken && exc_target == CEP_RESET_VEC)
      else $error("reset pin did not reach the reset vector");
   AST_SOFT_VEC: assert property (
      !master_clear_pin && soft_reset_req |=> exc_target == CEP_RESET_VEC)
      else $error("soft reset did not reach the reset vector");
   AST_DSS_VEC: assert property (
      s_rst_free ##0 debug_single_step |=> exc_target == CEP_DEBUG_VEC)
      else $error("single step did not reach the debug vector");
   AST_DEBUG_INTERRUPT_FLAG_VEC: assert property (
      s_rst_free ##0 external_debug_request_input
      |=> exc_taken && exc_target == CEP_DEBUG_VEC)
      else $error("debug request did not reach the debug vector");
   AST_NMI_VEC: assert property (
      s_dbg_free ##0 nmi_in |=> exc_target == CEP_RESET_VEC)
      else $error("nmi did not reach the reset vector");
   // base has zero low bits, so the offset shows alone there
   AST_MCHK_VEC: assert property (
      s_nmi_free ##0 tlb_write_conflict |=> exc_target[11:0] == 12'h180)
      else $error("machine check missed the general offset");
   AST_INT_VEC: assert property (
      s_nmi_free ##0 (int_req && !tlb_write_conflict)
      |=> exc_taken && exc_target == $past(int_vector))
      else $error("interrupt did not use its own vector");
   AST_RD_IDLE: assert property (
      !reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
endmodule : cep_prioritizer_chk

bind cep_prioritizer cep_prioritizer_chk u_chk (
   .clk_sys(clk_sys), .srst(srst), .master_clear_pin(master_clear_pin),
   .soft_reset_req(soft_reset_req), .debug_single_step(debug_single_step),
   .external_debug_request_input(external_debug_request_input),
   .nmi_in(nmi_in), .tlb_write_conflict(tlb_write_conflict),
   .int_req(int_req), .int_vector(int_vector), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .exc_taken(exc_taken), .exc_target(exc_target)
);
`default_nettype wire

// ==== verification/cep_pipe_model.sv ====
`default_nettype none
module cep_pipe_model (
   input wire logic clk_sys,
   output logic [cep_pkg::CEP_NEV-1:0] ev_req
);
   timeunit 1ns;
   timeprecision 1ps;
   import cep_pkg::*;
   // ---------------------------------------------------------------
   // event launch
   // ---------------------------------------------------------------
   initial ev_req = '0;
   // one cycle only: the core samples levels, so a longer pulse
   // would be taken as a second exception
   task automatic fire(input logic [CEP_NEV-1:0] m);
      @(posedge clk_sys);
      ev_req <= m;
      @(posedge clk_sys);
      ev_req <= '0;
   endtask : fire
endmodule : cep_pipe_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cep_pkg::*;
   typedef struct {
      logic [2:0] k;
      logic [15:0] st;
      logic [2:0] db;
      logic [5:0] cc;
   } cep_row_t;
   localparam logic [31:0] BASE = 32'h9D001000;
   localparam logic [31:0] IVEC = 32'h9D000200;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] exc_target;
   logic [31:0] rv;
   logic exc_taken;
   logic irq;
   logic [CEP_NEV-1:0] ev;
   logic [5:0] last_cc = 6'h00;
   int num_errors = 0;
   int cmp_count = 0;
   // kind 0 reset, 1 debug, 2 base+0x180, 3 base, 4 interrupt vector;
   // cause bit 5 set means the cause field keeps its old value
   cep_row_t rows [CEP_NEV] = '{
      '{3'h0, 16'h0042, 3'h0, 6'h20}, '{3'h0, 16'h004A, 3'h0, 6'h20},
      '{3'h1, 16'h0000, 3'h1, 6'h20}, '{3'h1, 16'h0000, 3'h2, 6'h20},
      '{3'h0, 16'h0046, 3'h0, 6'h20}, '{3'h2, 16'h0021, 3'h0, 6'h18},
      '{3'h4, 16'h0500, 3'h0, 6'h00}, '{3'h2, 16'h0011, 3'h0, 6'h17},
      '{3'h1, 16'h0000, 3'h4, 6'h20}, '{3'h2, 16'h0001, 3'h0, 6'h17},
      '{3'h2, 16'h0001, 3'h0, 6'h04}, '{3'h3, 16'h0000, 3'h0, 6'h02},
      '{3'h2, 16'h0001, 3'h0, 6'h14}, '{3'h2, 16'h0001, 3'h0, 6'h06}};

   always #20 clk_sys = ~clk_sys;

   cep_pipe_model pm (.clk_sys(clk_sys), .ev_req(ev));
   cep_prioritizer dut (
      .clk_sys(clk_sys), .srst(srst), .master_clear_pin(ev[CEP_E_RST]),
      .soft_reset_req(ev[CEP_E_SRST]), .debug_single_step(ev[CEP_E_DSS]),
      .external_debug_request_input(ev[CEP_E_DEBUG_INTERRUPT_FLAG]), .nmi_in(ev[CEP_E_NMI]),
      .tlb_write_conflict(ev[CEP_E_MCHK]), .int_req(ev[CEP_E_INT]),
      .int_level(3'h5), .int_vector(IVEC),
      .deferred_watch_unmask(ev[CEP_E_DWP]),
      .debug_instr_break(ev[CEP_E_DIB]), .fetch_watch_match(ev[CEP_E_WATCH]),
      .fetch_address_error(ev[CEP_E_FETCH_ADDRESS_ERROR]),
      .fetch_translation_miss(ev[CEP_E_FETCH_TRANSLATION_MISS]),
      .execute_inhibit_bit(ev[CEP_E_XI]), .fetch_bus_error(ev[CEP_E_IBE]),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exc_taken(exc_taken),
      .exc_target(exc_target), .irq(irq));
   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic launch(input logic [CEP_NEV-1:0] m,
                         input logic [31:0] t);
      pm.fire(m);
      #1;
      chk("taken", 32'h1, {31'h0, exc_taken});
      chk("target", t, exc_target);
   endtask : launch
   function automatic logic [31:0] tgt_of(input logic [2:0] k);
      case (k)
         3'h0: return CEP_RESET_VEC;
         3'h1: return CEP_DEBUG_VEC;
         3'h2: return BASE + CEP_GEN_OFS;
         3'h3: return BASE;
         default: return IVEC;
      endcase
   endfunction : tgt_of
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      chk("taken", 32'h0, {31'h0, exc_taken});
      chk("target", CEP_RESET_VEC, exc_target);
      rd(CEP_A_STATUS, rv);
      chk("status", 32'h42, rv);
      rd(CEP_A_BASE, rv);
      chk("base", CEP_BASE_RST, rv);
      rd(4'hF, rv);
      chk("unmapped", 32'h0, rv);
      wr(CEP_A_BASE, BASE);
      wr(CEP_A_IEN, 32'h3FFF);
      // one source at a time, flags cleared first so only its own show
      for (int i = 0; i < CEP_NEV; i++)
      begin
         wr(CEP_A_STATUS, 32'h0);
         wr(CEP_A_DEBUG, 32'h0);
         launch(CEP_NEV'(1) << i, tgt_of(rows[i].k));
         if (!rows[i].cc[5])
            last_cc = rows[i].cc;
         rd(CEP_A_STATUS, rv);
         chk("status", {16'h0, rows[i].st}, rv);
         rd(CEP_A_DEBUG, rv);
         chk("debug", {29'h0, rows[i].db}, rv);
         rd(CEP_A_CAUSE, rv);
         chk("cause", {27'h0, last_cc[4:0]}, rv);
         rd(CEP_A_ISTAT, rv);
         chk("istat", 32'h1 << i, rv);
         chk("irq", 32'h1, {31'h0, irq});
         wr(CEP_A_ICLR, 32'h1 << i);
         rd(CEP_A_ISTAT, rv);
         chk("irq clear", 32'h0, {31'h0, irq});
      end
      // every source at once: only the reset pin may win
      wr(CEP_A_STATUS, 32'h0);
      launch('1, CEP_RESET_VEC);
      rd(CEP_A_STATUS, rv);
      chk("status", 32'h42, rv);
      // with exl set a translation miss moves to the general offset
      wr(CEP_A_STATUS, 32'h1);
      launch(CEP_NEV'(1) << CEP_E_FETCH_TRANSLATION_MISS, BASE + CEP_GEN_OFS);
      rd(CEP_A_CAUSE, rv);
      chk("cause", 32'h02, rv);
      // break request bit raises a debug interrupt and clears itself
      wr(CEP_A_DEBUG, 32'h0);
      wr(CEP_A_DCTL, 32'h1);
      @(posedge clk_sys);
      #1;
      chk("target", CEP_DEBUG_VEC, exc_target);
      rd(CEP_A_DCTL, rv);
      chk("break", 32'h0, rv);
      rd(CEP_A_DEBUG, rv);
      chk("debug", 32'h2, rv);
      // masked event keeps irq low until enabled, then clear drops it
      wr(CEP_A_ICLR, 32'h3FFF);
      wr(CEP_A_IEN, 32'h0);
      launch(CEP_NEV'(1) << CEP_E_IBE, BASE + CEP_GEN_OFS);
      rd(CEP_A_ISTAT, rv);
      chk("istat", 32'h2000, rv);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(CEP_A_IEN, 32'h2000);
      rd(CEP_A_CAUSE, rv);
      chk("cause", 32'h06, rv);
      chk("irq", 32'h1, {31'h0, irq});
      wr(CEP_A_ICLR, 32'h2000);
      rd(CEP_A_CAUSE, rv);
      chk("irq clear", 32'h0, {31'h0, irq});
      tally_and_finish();
   end
   // watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      #(40 * 4000);
      num_errors++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
